// file: adc_trigger_gain_input_control.sv
`timescale 1ns/1ns
module adc_trigger_gain_input_control (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire adc_ctl_pkg::trig_flags_t trig_flags,
	input wire logic conversion_done_flag,
	input wire logic conversion_busy,
	input wire adc_ctl_pkg::raw_result_t raw_result,
	output adc_ctl_pkg::core_cfg_t core_cfg,
	output logic start_conversion,
	output logic [9:0] conversion_result,
	output logic result_valid,
	input wire logic [10:0] analog_pin_in,
	input wire logic reference_pin_in,
	output logic [10:0] analog_pin_read,
	output logic reference_pin_read,
	output logic [10:0] analog_input_off,
	output logic reference_input_off
);
	logic [7:0] converter_control_b_r;
	logic [7:0] analog_input_disable_0_r;
	logic [7:0] analog_input_disable_1_r;
	logic [7:0] control_a_r;
	logic [7:0] select_r;
	logic [5:0] active_channel_r;
	logic [2:0] active_ref_r;
	logic extended_r;
	logic start_r;
	logic [9:0] result_r;
	logic valid_r;
	logic [31:0] prdata_r;
	logic [2:0] trig_sel_r;
	logic setup;
	logic access;
	logic wr;
	logic mapped;
	logic [31:0] read_mux;
	logic [5:0] pending_channel;
	logic [2:0] pending_ref;
	logic trig_level;
	logic trig_rise;
	logic to_free;
	logic manual_start;
	logic auto_start;
	logic [11:0] pins_sync;
	logic [8:0] clipped;
	adc_ctl_pkg::trig_src_t trig_src;
	adc_ctl_pkg::ref_mode_t ref_mode;
	adc_ctl_pkg::gain_t gain;
	logic diff;

	// APB: read data captured in setup, so every access ends in one cycle
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = access;
	assign wr = access & pwrite & mapped;
	assign pslverr = access & ~mapped;

	always_comb begin
		mapped = 1'b1;
		read_mux = '0;
		case (paddr)
			adc_ctl_pkg::ADDR_CONTROL_A: begin
				read_mux[7:0] = control_a_r;
				read_mux[adc_ctl_pkg::START_BIT] = conversion_busy;
			end
			adc_ctl_pkg::ADDR_SELECT: read_mux[7:0] = select_r;
			// Bit 5 is masked at write time and so always reads zero
			adc_ctl_pkg::ADDR_CONTROL_B: read_mux[7:0] = converter_control_b_r;
			adc_ctl_pkg::ADDR_DISABLE_0: read_mux[7:0] = analog_input_disable_0_r;
			adc_ctl_pkg::ADDR_DISABLE_1: read_mux[7:0] = analog_input_disable_1_r;
			adc_ctl_pkg::ADDR_STATUS: begin
				read_mux[0] = conversion_busy;
				read_mux[1] = conversion_done_flag;
				read_mux[2] = extended_r;
				read_mux[6:4] = active_ref_r;
				read_mux[13:8] = active_channel_r;
			end
			adc_ctl_pkg::ADDR_RESULT: read_mux[9:0] = result_r;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata_r <= '0;
		end else if (setup & ~pwrite) begin
			prdata_r <= read_mux;
		end
	end
	assign prdata = prdata_r;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			converter_control_b_r <= adc_ctl_pkg::CONTROL_B_RESET;
		end else if (wr && paddr == adc_ctl_pkg::ADDR_CONTROL_B) begin
			converter_control_b_r <= pwdata[7:0] &
				adc_ctl_pkg::CONTROL_B_WMASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			analog_input_disable_0_r <= adc_ctl_pkg::DISABLE_RESET;
			analog_input_disable_1_r <= adc_ctl_pkg::DISABLE_RESET;
		end else if (wr && paddr == adc_ctl_pkg::ADDR_DISABLE_0) begin
			analog_input_disable_0_r <= pwdata[7:0] &
				adc_ctl_pkg::DISABLE_0_WMASK;
		end else if (wr && paddr == adc_ctl_pkg::ADDR_DISABLE_1) begin
			analog_input_disable_1_r <= pwdata[7:0] &
				adc_ctl_pkg::DISABLE_1_WMASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			control_a_r <= adc_ctl_pkg::CONTROL_A_RESET;
			select_r <= adc_ctl_pkg::SELECT_RESET;
		end else if (wr && paddr == adc_ctl_pkg::ADDR_CONTROL_A) begin
			control_a_r <= pwdata[7:0] & adc_ctl_pkg::CONTROL_A_WMASK;
		end else if (wr && paddr == adc_ctl_pkg::ADDR_SELECT) begin
			select_r <= pwdata[7:0] & adc_ctl_pkg::SELECT_WMASK;
		end
	end

	// Channel and reference follow software only between conversions
	assign pending_channel = {
		converter_control_b_r[adc_ctl_pkg::CHANNEL_MSB_BIT],
		select_r[adc_ctl_pkg::CHAN_LOW_HI:adc_ctl_pkg::CHAN_LOW_LO]};
	assign pending_ref = {
		converter_control_b_r[adc_ctl_pkg::REF_MSB_BIT],
		select_r[adc_ctl_pkg::REF_LOW_HI:adc_ctl_pkg::REF_LOW_LO]};

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			active_channel_r <= '0;
			active_ref_r <= '0;
		end else if (!conversion_busy) begin
			active_channel_r <= pending_channel;
			active_ref_r <= pending_ref;
		end
	end

	// A new reference is set even when a start clears it in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			extended_r <= 1'b0;
		end else if (!conversion_busy && pending_ref != active_ref_r) begin
			extended_r <= 1'b1;
		end else if (start_r) begin
			extended_r <= 1'b0;
		end
	end

	always_comb begin
		case (active_ref_r)
			3'b010: ref_mode = adc_ctl_pkg::REF_INT_1V1;
			3'b011: ref_mode = adc_ctl_pkg::REF_RESERVED;
			3'b110: ref_mode = adc_ctl_pkg::REF_INT_2V56;
			3'b111: ref_mode = adc_ctl_pkg::REF_INT_2V56_BYPASS;
			3'b001, 3'b101: ref_mode = adc_ctl_pkg::REF_EXTERNAL;
			default: ref_mode = adc_ctl_pkg::REF_VCC;
		endcase
	end

	// Boost only touches differential pairs with a boost option
	assign diff = adc_ctl_pkg::DIFF_MASK[active_channel_r];
	always_comb begin
		if (!diff) begin
			gain = adc_ctl_pkg::GAIN_1X;
		end else if (adc_ctl_pkg::HIGH_GAIN_MASK[active_channel_r]) begin
			gain = (converter_control_b_r[adc_ctl_pkg::GAIN_BOOST_BIT] &&
				active_channel_r[adc_ctl_pkg::CHANNEL_W-1]) ? adc_ctl_pkg::GAIN_32X :
				adc_ctl_pkg::GAIN_20X;
		end else begin
			gain = (converter_control_b_r[adc_ctl_pkg::GAIN_BOOST_BIT] &&
				active_channel_r[adc_ctl_pkg::CHANNEL_W-1]) ? adc_ctl_pkg::GAIN_8X :
				adc_ctl_pkg::GAIN_1X;
		end
	end

	always_comb begin
		core_cfg.bipolar =
			converter_control_b_r[adc_ctl_pkg::BIPOLAR_BIT];
		core_cfg.differential = diff;
		core_cfg.gain = gain;
		core_cfg.ref_mode = ref_mode;
		core_cfg.channel = active_channel_r;
		core_cfg.extended = extended_r;
	end

	// Trigger source selection
	assign trig_src = adc_ctl_pkg::trig_src_t'(
		converter_control_b_r[adc_ctl_pkg::TRIG_HI:adc_ctl_pkg::TRIG_LO]);

	always_comb begin
		case (trig_src)
			adc_ctl_pkg::TRIG_FREE: trig_level = conversion_done_flag;
			adc_ctl_pkg::TRIG_COMPARATOR: trig_level = trig_flags.comparator;
			adc_ctl_pkg::TRIG_EXT_INT0: trig_level = trig_flags.ext_int0;
			adc_ctl_pkg::TRIG_T0_CMP_A: trig_level = trig_flags.t0_cmp_a;
			adc_ctl_pkg::TRIG_T0_OVF: trig_level = trig_flags.t0_ovf;
			adc_ctl_pkg::TRIG_T0_CMP_B: trig_level = trig_flags.t0_cmp_b;
			adc_ctl_pkg::TRIG_T1_OVF: trig_level = trig_flags.t1_ovf;
			adc_ctl_pkg::TRIG_WATCHDOG: trig_level = trig_flags.watchdog;
			default: trig_level = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			trig_sel_r <= '0;
		end else begin
			trig_sel_r <= trig_src;
		end
	end

	// Entering free running masks the edge for that one cycle
	assign to_free = (trig_src == adc_ctl_pkg::TRIG_FREE) &&
		(trig_sel_r != adc_ctl_pkg::TRIG_FREE);

	trig_edge u_trig_edge (
		.sys_clk(sys_clk),
		.reset(reset),
		.level(trig_level),
		.suppress(to_free),
		.rise(trig_rise)
	);

	assign auto_start = control_a_r[adc_ctl_pkg::AUTO_TRIG_BIT] &&
		control_a_r[adc_ctl_pkg::ENABLE_BIT] && trig_rise;
	assign manual_start = wr && paddr == adc_ctl_pkg::ADDR_CONTROL_A &&
		pwdata[adc_ctl_pkg::START_BIT] && pwdata[adc_ctl_pkg::ENABLE_BIT];

	// Starts while busy are dropped; the core cannot queue them
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			start_r <= 1'b0;
		end else begin
			start_r <= (auto_start | manual_start) & ~conversion_busy;
		end
	end
	assign start_conversion = start_r;

	// Result formatting
	assign clipped = (raw_result.magnitude > {1'b0, adc_ctl_pkg::MAG_MAX}) ?
		adc_ctl_pkg::MAG_MAX : raw_result.magnitude[8:0];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			result_r <= '0;
		end else if (raw_result.valid) begin
			if (converter_control_b_r[adc_ctl_pkg::BIPOLAR_BIT]) begin
				result_r <= raw_result.negative ?
					10'(-{1'b0, clipped}) : {1'b0, clipped};
			end else if (raw_result.negative) begin
				result_r <= adc_ctl_pkg::SATURATED;
			end else begin
				result_r <= raw_result.magnitude;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= raw_result.valid;
		end
	end
	assign conversion_result = result_r;
	assign result_valid = valid_r;

	// Digital input buffers and pin reads
	pin_sync #(
		.WIDTH(adc_ctl_pkg::PIN_COUNT + 1)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in({reference_pin_in, analog_pin_in}),
		.pin_out(pins_sync)
	);

	assign analog_input_off = {analog_input_disable_1_r[7:4],
		analog_input_disable_0_r[7:4], analog_input_disable_0_r[2:0]};
	assign reference_input_off =
		analog_input_disable_0_r[adc_ctl_pkg::REF_PIN_OFF_BIT];
	assign analog_pin_read = pins_sync[10:0] & ~analog_input_off;
	assign reference_pin_read = pins_sync[11] & ~reference_input_off;
endmodule

// file: adc_ctl_pkg.sv
package adc_ctl_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PIN_COUNT = 11;
	localparam int unsigned CHANNEL_W = 6;
	localparam int unsigned RESULT_W = 10;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CONTROL_A = 6'h00;
	localparam logic [5:0] IDX_SELECT = 6'h01;
	localparam logic [5:0] IDX_CONTROL_B = 6'h03;
	localparam logic [5:0] IDX_DISABLE_0 = 6'h04;
	localparam logic [5:0] IDX_DISABLE_1 = 6'h05;
	localparam logic [5:0] IDX_STATUS = 6'h06;
	localparam logic [5:0] IDX_RESULT = 6'h07;
	localparam logic [7:0] ADDR_CONTROL_A = {IDX_CONTROL_A, 2'b00};
	localparam logic [7:0] ADDR_SELECT = {IDX_SELECT, 2'b00};
	localparam logic [7:0] ADDR_CONTROL_B = {IDX_CONTROL_B, 2'b00};
	localparam logic [7:0] ADDR_DISABLE_0 = {IDX_DISABLE_0, 2'b00};
	localparam logic [7:0] ADDR_DISABLE_1 = {IDX_DISABLE_1, 2'b00};
	localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [7:0] ADDR_RESULT = {IDX_RESULT, 2'b00};

	// Reset values
	localparam logic [7:0] CONTROL_B_RESET = 8'h00;
	localparam logic [7:0] DISABLE_RESET = 8'h00;
	localparam logic [7:0] CONTROL_A_RESET = 8'h00;
	localparam logic [7:0] SELECT_RESET = 8'h00;

	// Control register B fields
	localparam int BIPOLAR_BIT = 7;
	localparam int GAIN_BOOST_BIT = 6;
	localparam int REF_MSB_BIT = 4;
	localparam int CHANNEL_MSB_BIT = 3;
	localparam int TRIG_HI = 2;
	localparam int TRIG_LO = 0;
	localparam logic [7:0] CONTROL_B_WMASK = 8'hdf;

	// Control register A fields
	localparam int ENABLE_BIT = 7;
	localparam int START_BIT = 6;
	localparam int AUTO_TRIG_BIT = 5;
	localparam logic [7:0] CONTROL_A_WMASK = 8'ha0;

	// Select register fields
	localparam int REF_LOW_HI = 7;
	localparam int REF_LOW_LO = 6;
	localparam int CHAN_LOW_HI = 4;
	localparam int CHAN_LOW_LO = 0;
	localparam logic [7:0] SELECT_WMASK = 8'hdf;

	// Input disable fields
	localparam int REF_PIN_OFF_BIT = 3;
	localparam logic [7:0] DISABLE_0_WMASK = 8'hff;
	localparam logic [7:0] DISABLE_1_WMASK = 8'hf0;

	// Channel decode masks, one bit per selector value
	localparam logic [63:0] DIFF_MASK = 64'h7fffffff_3ffff800;
	localparam logic [63:0] HIGH_GAIN_MASK = 64'h7d555555_1ad66800;

	localparam logic [9:0] SATURATED = 10'h3ff;
	localparam logic [8:0] MAG_MAX = 9'h1ff;

	// Extended conversion length in converter clock cycles
	localparam int unsigned LONG_CONV_CYCLES = 25;

	typedef enum logic [2:0] {
		TRIG_FREE,
		TRIG_COMPARATOR,
		TRIG_EXT_INT0,
		TRIG_T0_CMP_A,
		TRIG_T0_OVF,
		TRIG_T0_CMP_B,
		TRIG_T1_OVF,
		TRIG_WATCHDOG
	} trig_src_t;

	typedef enum logic [2:0] {
		REF_VCC,
		REF_EXTERNAL,
		REF_INT_1V1,
		REF_RESERVED,
		REF_INT_2V56,
		REF_INT_2V56_BYPASS
	} ref_mode_t;

	typedef enum logic [1:0] {GAIN_1X, GAIN_8X, GAIN_20X, GAIN_32X} gain_t;

	typedef struct packed {
		logic comparator;
		logic ext_int0;
		logic t0_cmp_a;
		logic t0_ovf;
		logic t0_cmp_b;
		logic t1_ovf;
		logic watchdog;
	} trig_flags_t;

	typedef struct packed {
		logic bipolar;
		logic differential;
		gain_t gain;
		ref_mode_t ref_mode;
		logic [CHANNEL_W-1:0] channel;
		logic extended;
	} core_cfg_t;

	typedef struct packed {
		logic valid;
		logic negative;
		logic [RESULT_W-1:0] magnitude;
	} raw_result_t;

endpackage

// file: pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A bit changes only once the last two stages agree
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pin_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					pin_out[i] <= s3_r[i];
				end
			end
		end
	end
endmodule

// file: trig_edge.sv
`timescale 1ns/1ns
module trig_edge (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic level,
	input wire logic suppress,
	output logic rise
);
	logic level_r;

	// Level is kept whatever the source, so a switch of source can rise
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			level_r <= 1'b0;
		end else begin
			level_r <= level;
		end
	end

	assign rise = level & ~level_r & ~suppress;
endmodule

// file: adc_core_model.sv
`timescale 1ns/1ns
module adc_core_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic start_conversion,
	input wire logic neg,
	input wire logic [9:0] mag,
	output logic conversion_done_flag,
	output logic conversion_busy,
	output adc_ctl_pkg::raw_result_t raw_result
);
	logic [2:0] cnt_r;
	// Fields carry inverted data outside the valid pulse to expose stale use
	always_ff @(posedge sys_clk) begin
		raw_result <= {1'b0, ~neg, ~mag};
		if (reset) begin
			cnt_r <= 3'h0;
			conversion_busy <= 1'b0;
			conversion_done_flag <= 1'b0;
		end else if (start_conversion) begin
			cnt_r <= 3'h4;
			conversion_busy <= 1'b1;
			conversion_done_flag <= 1'b0;
		end else if (cnt_r == 3'h1) begin
			cnt_r <= 3'h0;
			conversion_busy <= 1'b0;
			conversion_done_flag <= 1'b1;
			raw_result <= {1'b1, neg, mag};
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end
endmodule

// file: adc_ctl_monitor.sv
`timescale 1ns/1ns
module adc_ctl_monitor (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic conversion_busy,
	input wire adc_ctl_pkg::raw_result_t raw_result,
	input wire adc_ctl_pkg::core_cfg_t core_cfg,
	input wire logic start_conversion,
	input wire logic [9:0] conversion_result,
	input wire logic result_valid,
	input wire logic [10:0] analog_pin_read,
	input wire logic reference_pin_read,
	input wire logic [10:0] analog_input_off,
	input wire logic reference_input_off
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	wire wr_acc = psel && penable && pwrite;
	ready_a: assert property (pready == (psel && penable))
		else $error("pready wrong");
	bit5_zero_a: assert property (
		psel && !penable && !pwrite && paddr == adc_ctl_pkg::ADDR_CONTROL_B
		|=> prdata[5] == 1'b0) else $error("bit 5 set");
	bipolar_mode_a: assert property (
		wr_acc && paddr == adc_ctl_pkg::ADDR_CONTROL_B
		|=> core_cfg.bipolar == $past(pwdata[7])) else $error("bipolar");
	disable_low_a: assert property (
		wr_acc && paddr == adc_ctl_pkg::ADDR_DISABLE_0 |=>
		{analog_input_off[6:3], reference_input_off,
		analog_input_off[2:0]} == $past(pwdata[7:0]))
		else $error("disable 0 map");
	disable_high_a: assert property (
		wr_acc && paddr == adc_ctl_pkg::ADDR_DISABLE_1
		|=> analog_input_off[10:7] == $past(pwdata[7:4]))
		else $error("disable 1 map");
	pin_mask_a: assert property (
		(analog_pin_read & analog_input_off) == 11'h000
		&& !(reference_pin_read && reference_input_off))
		else $error("disabled pin reads one");
	idle_start_a: assert property (
		start_conversion |-> !$past(conversion_busy) ##1 !start_conversion)
		else $error("bad start pulse");
	channel_hold_a: assert property (
		$past(conversion_busy) && !$past(reset) |-> $stable(core_cfg.channel))
		else $error("channel moved in conversion");
	saturate_a: assert property (
		raw_result.valid && raw_result.negative && !core_cfg.bipolar
		|=> result_valid && conversion_result == 10'h3ff)
		else $error("no saturation");
	twos_result_a: assert property (
		raw_result.valid && raw_result.negative && core_cfg.bipolar
		&& raw_result.magnitude <= 10'h1ff
		|=> conversion_result == 10'h000 - $past(raw_result.magnitude))
		else $error("bipolar result");
	reset_clear_a: assert property (
		disable iff (1'b0) reset |=> analog_input_off == 11'h000
		&& !reference_input_off && !core_cfg.bipolar) else $error("reset");
endmodule

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [6:0] trig_flags = 7'h00;
	logic [10:0] analog_pin_in = 11'h000;
	logic reference_pin_in = 1'b0;
	logic neg = 1'b0;
	logic [9:0] mag = 10'h000;
	logic [31:0] prdata, q;
	logic pready, pslverr, err, conversion_done_flag, conversion_busy;
	logic start_conversion, result_valid, reference_pin_read;
	logic reference_input_off;
	logic [9:0] conversion_result;
	logic [9:0] last_res = 10'h000;
	logic [10:0] analog_pin_read, analog_input_off;
	adc_ctl_pkg::raw_result_t raw_result;
	adc_ctl_pkg::core_cfg_t core_cfg;
	logic [7:0] cb [4] = '{8'h08, 8'h58, 8'h58, 8'h18};
	logic [7:0] sl [4] = '{8'h80, 8'h80, 8'hc1, 8'hc1};
	logic [1:0] gn [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
	logic [2:0] rf [4] = '{3'h2, 3'h4, 3'h5, 3'h5};
	logic [9:0] res_e [3] = '{10'h3ff, 10'h3fb, 10'h1ff};
	int starts = 0;
	int n0;
	int mismatches = 0;
	int cmp_count = 0;

	always #25 sys_clk = ~sys_clk;

	adc_trigger_gain_input_control i_dut (.sys_clk, .reset, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .trig_flags,
		.conversion_done_flag, .conversion_busy, .raw_result, .core_cfg,
		.start_conversion, .conversion_result, .result_valid,
		.analog_pin_in, .reference_pin_in, .analog_pin_read,
		.reference_pin_read, .analog_input_off, .reference_input_off);
	adc_core_model i_core (.sys_clk, .reset, .start_conversion, .neg, .mag,
		.conversion_done_flag, .conversion_busy, .raw_result);

	always @(posedge sys_clk) begin
		if (start_conversion === 1'b1) starts <= starts + 1;
		if (result_valid === 1'b1) last_res <= conversion_result;
	end

	task automatic close_out;
		if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// One edge passes after release so back-to-back calls never clash
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge sys_clk);
		penable <= 1'b1;
		// The wait ends on pready; nothing but the watchdog ends it if pready never comes
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(q, e);
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		rd(adc_ctl_pkg::ADDR_CONTROL_B, 32'h0);
		rd(adc_ctl_pkg::ADDR_DISABLE_0, 32'h0);
		rd(adc_ctl_pkg::ADDR_DISABLE_1, 32'h0);
		chk(core_cfg.bipolar, 1'b0);
		wr(adc_ctl_pkg::ADDR_CONTROL_B, 32'hff);
		rd(adc_ctl_pkg::ADDR_CONTROL_B, 32'hdf);
		rd(8'h20, 32'h0);
		chk(err, 1'b1);
		wr(adc_ctl_pkg::ADDR_CONTROL_B, 32'h0);
		wr(adc_ctl_pkg::ADDR_DISABLE_0, 32'hff);
		wr(adc_ctl_pkg::ADDR_DISABLE_1, 32'hff);
		rd(adc_ctl_pkg::ADDR_DISABLE_1, 32'hf0);
		analog_pin_in <= 11'h7ff;
		reference_pin_in <= 1'b1;
		tick(6);
		chk(analog_pin_read, 11'h000);
		chk(reference_pin_read, 1'b0);
		wr(adc_ctl_pkg::ADDR_DISABLE_0, 32'ha5);
		wr(adc_ctl_pkg::ADDR_DISABLE_1, 32'h50);
		tick(2);
		chk(analog_input_off, 11'h2d5);
		chk(analog_pin_read, 11'h52a);
		chk(reference_pin_read, 1'b1);
		wr(adc_ctl_pkg::ADDR_CONTROL_A, 32'ha0);
		rd(adc_ctl_pkg::ADDR_CONTROL_A, 32'ha0);
		for (int s = 1; s < 8; s++) begin
			wr(adc_ctl_pkg::ADDR_CONTROL_B, s);
			n0 = starts;
			trig_flags[7 - s] <= 1'b1;
			tick(4);
			chk(starts - n0, 1);
			trig_flags <= 7'h00;
			tick(8);
		end
		wr(adc_ctl_pkg::ADDR_CONTROL_A, 32'h80);
		wr(adc_ctl_pkg::ADDR_CONTROL_B, 32'h1);
		n0 = starts;
		trig_flags <= 7'h40;
		tick(4);
		chk(starts - n0, 0);
		trig_flags <= 7'h00;
		wr(adc_ctl_pkg::ADDR_CONTROL_A, 32'ha0);
		wr(adc_ctl_pkg::ADDR_CONTROL_B, 32'h2);
		trig_flags <= 7'h40;
		tick(2);
		n0 = starts;
		wr(adc_ctl_pkg::ADDR_CONTROL_B, 32'h1);
		tick(2);
		chk(starts - n0, 1);
		trig_flags <= 7'h00;
		tick(8);
		n0 = starts;
		wr(adc_ctl_pkg::ADDR_CONTROL_B, 32'h0);
		tick(4);
		chk(starts - n0, 0);
		for (int i = 0; i < 3; i++) begin
			wr(adc_ctl_pkg::ADDR_CONTROL_B, {24'h0, i > 0, 7'h0});
			chk(core_cfg.bipolar, i > 0);
			neg <= i < 2;
			mag <= i < 2 ? 10'h005 : 10'h300;
			wr(adc_ctl_pkg::ADDR_CONTROL_A, 32'hc0);
			tick(10);
			chk(last_res, res_e[i]);
			rd(adc_ctl_pkg::ADDR_RESULT, {22'h0, res_e[i]});
		end
		// Channel written while busy must wait for the conversion to end
		wr(adc_ctl_pkg::ADDR_CONTROL_A, 32'hc0);
		wr(adc_ctl_pkg::ADDR_SELECT, 32'h07);
		chk(core_cfg.channel, 6'h00);
		tick(6);
		chk(core_cfg.channel, 6'h07);
		for (int i = 0; i < 4; i++) begin
			wr(adc_ctl_pkg::ADDR_CONTROL_B, {24'h0, cb[i]});
			wr(adc_ctl_pkg::ADDR_SELECT, {24'h0, sl[i]});
			tick(2);
			chk(core_cfg.gain, gn[i]);
			chk(core_cfg.ref_mode, rf[i]);
			chk(core_cfg.channel, {cb[i][3], sl[i][4:0]});
			chk(core_cfg.differential, 1'b1);
			if (i == 0) begin
				chk(core_cfg.extended, 1'b1);
				rd(adc_ctl_pkg::ADDR_STATUS, 32'h2026);
			end
		end
		// Second reset with every register holding nonzero contents
		reset <= 1'b1;
		tick(5);
		reset <= 1'b0;
		tick(1);
		rd(adc_ctl_pkg::ADDR_CONTROL_B, 32'h0);
		rd(adc_ctl_pkg::ADDR_DISABLE_0, 32'h0);
		rd(adc_ctl_pkg::ADDR_DISABLE_1, 32'h0);
		chk(core_cfg.channel, 6'h00);
		close_out;
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		mismatches++;
		close_out;
	end
endmodule

bind adc_trigger_gain_input_control adc_ctl_monitor i_mon (.sys_clk,
	.reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
	.conversion_busy, .raw_result, .core_cfg, .start_conversion,
	.conversion_result, .result_valid, .analog_pin_read,
	.reference_pin_read, .analog_input_off, .reference_input_off);
